// ==== include/sbw_pkg.sv ====
// Purpose : Shared constants for the async byte-write SRAM host port
// Assumes : 100 MHz ref_clk, fastest speed grade timings
// Notes   : Cycle counts derive from ns figures; minimums round up
package sbw_pkg;
    localparam int ADDR_W      = 14;
    localparam int DATA_W      = 16;
    localparam int CLK_PS      = 10000;
    // Timings in ns as printed, fastest grade
    localparam int T_AA_NS     = 12;   // Address to data valid
    localparam int T_OE_NS     = 5;    // Output enable to data valid
    localparam int T_AW_NS     = 10;   // Address valid to end of write
    localparam int T_CW_NS     = 12;   // Selected to end of write
    localparam int T_DW_NS     = 5;    // Data valid to strobe rise
    localparam int T_BW_NS     = 6;    // Byte strobe low to strobe rise
    localparam int T_BH_NS     = 2;    // Byte strobe hold after rise
    localparam int T_WR_NS     = 5;    // Write high to output active
    function automatic int ns2cyc(input int ns);
        int c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RD_CYC  = ns2cyc(T_AA_NS) + 1;  // Plus one for the input synchroniser
    localparam int WR_CYC  = ns2cyc(T_CW_NS);
    localparam int HLD_CYC = ns2cyc(T_WR_NS);
    localparam logic [3:0] RD_CNT  = 4'(RD_CYC);
    localparam logic [3:0] WR_CNT  = 4'(WR_CYC);
    localparam logic [3:0] HLD_CNT = 4'(HLD_CYC);
    localparam logic [3:0] CNT_ZERO = 4'h0;
    typedef enum logic [2:0] {
        SBW_IDLE  = 3'b000,
        SBW_SETUP = 3'b001,
        SBW_READ  = 3'b011,
        SBW_WRITE = 3'b010,
        SBW_HOLD  = 3'b110
    } sbw_state_t;
endpackage

// ==== include/sbw_sync_if.sv ====
// Purpose : Carrier between the host port and its data-pin synchroniser
// Assumes : One clock domain
// Notes   : Raw pin level in, two-flop result out
`timescale 1ns/1ps
`default_nettype none
interface sbw_sync_if;
    logic [15:0] raw;
    logic [15:0] synced;
    modport owner (output raw, input synced);
    modport sync  (input raw, output synced);
endinterface
`default_nettype wire

// ==== design/sbw_sync.sv ====
// Purpose : Two-flop synchroniser for the data pins read back from memory
// Assumes : Single clock, synchronous active-low reset
// Notes   : First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module sbw_sync
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // Carrier
    sbw_sync_if.sync  port
);
    logic [15:0] stage1;
    logic [15:0] stage2;
    // Two register stages
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            stage1 <= 16'h0000;
            stage2 <= 16'h0000;
        end
        else
        begin
            stage1 <= port.raw;
            stage2 <= stage1;
        end
    end
    assign port.synced = stage2;
endmodule // sbw_sync
`default_nettype wire

// ==== design/sbw_host.sv ====
// Purpose : Host controller driving an async 16K x 16 byte-write SRAM
// Assumes : 100 MHz ref_clk, fastest speed grade, pins registered
// Notes   : One request at a time; req_ready low while busy
`timescale 1ns/1ps
`default_nettype none
module sbw_host
    import sbw_pkg::*;
(
    // Clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    // User request
    input  wire logic                     req_valid,
    input  wire logic                     req_write,
    input  wire logic [sbw_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [sbw_pkg::DATA_W-1:0] req_wdata,
    input  wire logic [1:0]               req_lanes,
    output logic                          req_ready,
    // User answer
    output logic                          rsp_valid,
    output logic [sbw_pkg::DATA_W-1:0]    rsp_rdata,
    // Memory pins
    output logic [sbw_pkg::ADDR_W-1:0]    mem_addr,
    output logic                          select_high,
    output logic                          select_low_n,
    output logic                          write_n,
    output logic                          low_byte_strobe_n,
    output logic                          high_byte_strobe_n,
    output logic                          out_enable_n,
    input  wire logic [sbw_pkg::DATA_W-1:0] data_pins_in,
    output logic [sbw_pkg::DATA_W-1:0]    data_pins_out,
    output logic                          data_pins_oe
);
    import sbw_pkg::*;

    sbw_state_t       state;
    sbw_state_t       next_state;
    logic [3:0]       cnt;
    logic [3:0]       next_cnt;
    logic             is_write;
    sbw_sync_if       sync_bus ();

    // ************************************************
    // Pin synchroniser
    // ************************************************
    assign sync_bus.raw = data_pins_in;
    sbw_sync u_sync
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .port    (sync_bus.sync)
    );

    // ************************************************
    // Sequencing
    // ************************************************
    wire take      = (state == SBW_IDLE) && req_valid;
    wire cnt_done  = (cnt == CNT_ZERO);
    // Active-low lanes; with no lane requested the write still runs with both lane strobes high
    wire [1:0] lanes_n = ~req_lanes;

    // Next-state decode
    always_comb
    begin
        next_state = state;
        next_cnt   = (cnt == CNT_ZERO) ? CNT_ZERO : cnt - 4'h1;
        case (state)
            SBW_IDLE:
            begin
                if (req_valid)
                begin
                    next_state = SBW_SETUP;
                end
            end
            // address settled a cycle before selection
            SBW_SETUP:
            begin
                next_state = is_write ? SBW_WRITE : SBW_READ;
                next_cnt   = is_write ? WR_CNT : RD_CNT;
            end
            SBW_READ:
            begin
                if (cnt_done)
                begin
                    next_state = SBW_HOLD;
                    next_cnt   = HLD_CNT;
                end
            end
            // strobe and selection held WR_CNT plus one cycles
            SBW_WRITE:
            begin
                if (cnt_done)
                begin
                    next_state = SBW_HOLD;
                    next_cnt   = HLD_CNT;
                end
            end
            SBW_HOLD:
            begin
                if (cnt_done)
                begin
                    next_state = SBW_IDLE;
                end
            end
            default:
            begin
                next_state = SBW_IDLE;
                next_cnt   = CNT_ZERO;
            end
        endcase
    end

    // State registers
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            state <= SBW_IDLE;
            cnt   <= CNT_ZERO;
        end
        else
        begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    // Latch request; address only moves in idle or in reset
    // address changes only with strobe high
    // address held from take to write end
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            is_write <= 1'b0;
            // A reset that cuts a write moves neither address nor data until the strobe is up
            if (write_n)
            begin
                mem_addr      <= '0;
                data_pins_out <= '0;
            end
        end
        else if (take)
        begin
            is_write      <= req_write;
            mem_addr      <= req_addr;
            data_pins_out <= req_wdata;
        end
    end

    // Lane strobes set with request, held through hold phase
    // lane bit 0 low byte, bit 1 high byte
    // lanes held in hold phase after strobe rise
    // lanes low from take, ahead of strobe
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            // lanes stay put at a strobe rise forced by reset
            if (write_n)
            begin
                low_byte_strobe_n  <= 1'b1;
                high_byte_strobe_n <= 1'b1;
            end
        end
        else if (take)
        begin
            low_byte_strobe_n  <= lanes_n[0] | ~req_write;
            high_byte_strobe_n <= lanes_n[1] | ~req_write;
        end
        else if (state == SBW_IDLE)
        begin
            low_byte_strobe_n  <= 1'b1;
            high_byte_strobe_n <= 1'b1;
        end
    end

    // ************************************************
    // Pin drive
    // ************************************************
    wire next_sel   = (next_state == SBW_READ) || (next_state == SBW_WRITE);
    // strobe only in write, enable only in read
    wire next_wr_n  = !(next_state == SBW_WRITE);
    wire next_oe_n  = !(next_state == SBW_READ);
    // Write flag as it will stand in setup
    wire cur_write  = take ? req_write : is_write;
    // data driven from setup through hold
    wire next_drive = cur_write && (next_state != SBW_IDLE) && (next_state != SBW_READ);

    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            select_high  <= 1'b0;
            select_low_n <= 1'b1;
            write_n      <= 1'b1;
            out_enable_n <= 1'b1;
            // Data stays on until the strobe is up
            data_pins_oe <= data_pins_oe && !write_n;
        end
        else
        begin
            select_high  <= next_sel;
            select_low_n <= !next_sel;
            write_n      <= next_wr_n;
            out_enable_n <= next_oe_n;
            data_pins_oe <= next_drive;
        end
    end

    // ************************************************
    // Answer
    // ************************************************
    // capture after access time plus sync delay
    always_ff @(posedge ref_clk)
    begin
        if (!resetn)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= '0;
            req_ready <= 1'b0;
        end
        else
        begin
            rsp_valid <= (state == SBW_READ) && cnt_done;
            if ((state == SBW_READ) && cnt_done)
            begin
                rsp_rdata <= sync_bus.synced;
            end
            req_ready <= (next_state == SBW_IDLE);
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    // no write strobe while output enabled
    chk_read_no_wr: assert property (@(posedge ref_clk) disable iff (!resetn)
        !out_enable_n |-> write_n)
        else $error("write strobe low during read");
    // no output enable while write strobe low
    chk_write_no_oe: assert property (@(posedge ref_clk) disable iff (!resetn)
        !write_n |-> out_enable_n && data_pins_oe)
        else $error("output enable low during write");
    chk_addr_stable: assert property (@(posedge ref_clk) disable iff (!resetn)
        !write_n && !$past(write_n) |-> $stable(mem_addr))
        else $error("address moved during write strobe");
    chk_addr_before: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(select_high) |-> $stable(mem_addr))
        else $error("address changed with select");
    chk_sel_pair: assert property (@(posedge ref_clk) disable iff (!resetn)
        select_high == !select_low_n)
        else $error("selects disagree");
    // write pulse lasts WR_CYC plus one cycles
    chk_write_len: assert property (@(posedge ref_clk) disable iff (!resetn)
        $fell(write_n) |-> !write_n [*3] ##1 write_n)
        else $error("write pulse length wrong");
    // lane strobes steady one cycle after strobe rise
    chk_lane_hold: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(write_n) |-> $stable(low_byte_strobe_n) && $stable(high_byte_strobe_n))
        else $error("lane strobe moved at strobe rise");
    // data still driven and unchanged one cycle after strobe rise
    chk_data_window: assert property (@(posedge ref_clk) disable iff (!resetn)
        $rose(write_n) |-> data_pins_oe && $stable(data_pins_out))
        else $error("write data not held");
endmodule // sbw_host
`default_nettype wire

// ==== tb/sbw_mem_model.sv ====
// Purpose : Behavioural async 16K x 16 byte-write memory
// Assumes : Pins come straight from the host port
// Notes   : Host timing faults are counted in viol
`timescale 1ns/1ps
`default_nettype none
module sbw_mem_model
    import sbw_pkg::*;
(
    // Host pins
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic              select_high,
    input  wire logic              select_low_n,
    input  wire logic              write_n,
    input  wire logic              low_byte_strobe_n,
    input  wire logic              high_byte_strobe_n,
    input  wire logic              out_enable_n,
    input  wire logic [DATA_W-1:0] data_pins,
    // Read drive and fault count
    output logic [DATA_W-1:0]      mem_q,
    output logic                   mem_drv,
    output var int                 viol
);
    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
    realtime           t_a = 0, t_g = 0, t_d = 0, t_l = 0;
    logic              wr_ok = 1'b1;
    wire sel = select_high & ~select_low_n;
    initial
    begin
        foreach (mem[i]) mem[i] = '0;
        viol = 0;
    end
    // address moves only with the strobe high
    always @(mem_addr)
    begin
        t_a = $realtime;
        if (sel && !write_n) viol++;
    end
    always @(negedge out_enable_n) t_g = $realtime;
    always @(data_pins) t_d = $realtime;
    always @(negedge low_byte_strobe_n or negedge high_byte_strobe_n) t_l = $realtime;
    // setup at the end of a write; recovery
    always @(posedge write_n)
    begin
        if (sel && ($realtime - t_a < T_AW_NS || $realtime - t_d < T_DW_NS)) viol++;
        if (sel && $realtime - t_l < T_BW_NS) viol++;
        wr_ok = 1'b0;
        #(T_WR_NS) wr_ok = 1'b1;
    end
    // lane writes during the strobe overlap
    always @*
    begin
        if (sel && !write_n && !low_byte_strobe_n) mem[mem_addr][7:0] = data_pins[7:0];
        if (sel && !write_n && !high_byte_strobe_n) mem[mem_addr][15:8] = data_pins[15:8];
    end
    // drive only on a selected read
    assign mem_drv = sel & write_n & ~out_enable_n & wr_ok;
    // data wrong until address and enable access times pass
    always #1
    begin
        mem_q = ($realtime - t_a >= T_AA_NS && $realtime - t_g >= T_OE_NS) ?
                mem[mem_addr] : ~mem[mem_addr];
    end
endmodule // sbw_mem_model
`default_nettype wire

// ==== tb/async_byte_write_sram_port_tb_top.sv ====
// Purpose : Self-checking bench for the SRAM host port
// Assumes : 100 MHz ref_clk, behavioural memory on the pins
// Notes   : Lane corners plus random traffic from seed 16
`timescale 1ns/1ps
`default_nettype none
module async_byte_write_sram_port_tb_top;
    import sbw_pkg::*;
    logic              ref_clk = 1'b0;
    logic              resetn = 1'b0;
    logic              req_valid = 1'b0;
    logic              req_write = 1'b0;
    logic [ADDR_W-1:0] req_addr = '0;
    logic [DATA_W-1:0] req_wdata = '0;
    logic [1:0]        req_lanes = 2'h0;
    logic [DATA_W-1:0] last_bus = '0;
    logic [DATA_W-1:0] shadow [0:(1<<ADDR_W)-1];
    int                err_count = 0, num_checks = 0, cycles = 0, viol;
    wire logic         req_ready, rsp_valid, select_high, select_low_n, write_n;
    wire logic         low_byte_strobe_n, high_byte_strobe_n, out_enable_n;
    wire logic         data_pins_oe, mem_drv;
    wire logic [ADDR_W-1:0] mem_addr;
    wire logic [DATA_W-1:0] rsp_rdata, data_pins_out, data_pins_in, mem_q;

    sbw_host dut (.ref_clk, .resetn, .req_valid, .req_write, .req_addr, .req_wdata,
        .req_lanes, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr, .select_high,
        .select_low_n, .write_n, .low_byte_strobe_n, .high_byte_strobe_n, .out_enable_n,
        .data_pins_in, .data_pins_out, .data_pins_oe);
    sbw_mem_model model (.mem_addr, .select_high, .select_low_n, .write_n,
        .low_byte_strobe_n, .high_byte_strobe_n, .out_enable_n, .data_pins(data_pins_in),
        .mem_q, .mem_drv, .viol);

    // Wire level: host, memory, else a float that toggles
    assign data_pins_in = data_pins_oe ? data_pins_out : (mem_drv ? mem_q : ~last_bus);
    always @(posedge ref_clk) last_bus <= data_pins_in;
    initial forever #5 ref_clk = ~ref_clk;

    task automatic end_of_test();
        if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: flag %b not %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: word %h not %h", $time, got, exp);
        end
    endtask
    // Expected word after a lane-masked write
    function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, d,
                                                input logic [1:0] ln);
        return {ln[1] ? d[15:8] : o[15:8], ln[0] ? d[7:0] : o[7:0]};
    endfunction

    // One request, then pin checks or read-back compare
    task automatic access(input logic wr, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input logic [1:0] ln);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40)
        begin
            @(negedge ref_clk);
            n++;
        end
        req_valid = 1'b1;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_lanes = ln;
        @(negedge ref_clk);
        req_valid = 1'b0;
        n = 0;
        while ((wr ? write_n !== 1'b0 : rsp_valid !== 1'b1) && n < 20)
        begin
            @(negedge ref_clk);
            n++;
        end
        if (wr)
        begin
            chk_bit(select_high & ~select_low_n, 1'b1);
            chk_bit(low_byte_strobe_n, ~ln[0]);
            chk_bit(high_byte_strobe_n, ~ln[1]);
            shadow[a] = merge(shadow[a], d, ln);
        end
        else
        begin
            chk_bit(n == 1 + RD_CYC + 1, 1'b1);
            chk_word(rsp_rdata, shadow[a]);
        end
    endtask

    // Pin watch each cycle and hang limit
    always @(negedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            end_of_test();
        end
        if (resetn)
        begin
            chk_bit(data_pins_oe & mem_drv, 1'b0);
            if (write_n === 1'b0) chk_bit(out_enable_n, 1'b1);
            if (out_enable_n === 1'b0) chk_bit(write_n, 1'b1);
        end
    end

    initial
    begin
        foreach (shadow[j]) shadow[j] = '0;
        void'($urandom(16));
        repeat (5) @(negedge ref_clk);
        chk_bit(select_high, 1'b0);
        chk_bit(data_pins_oe, 1'b0);
        chk_bit(mem_drv, 1'b0);
        resetn = 1'b1;
        // Every lane code at both address ends, each read back
        for (int k = 0; k < 8; k++)
        begin
            access(1'b1, {ADDR_W{k[0]}}, 16'($urandom), 2'(k >> 1));
            access(1'b0, {ADDR_W{k[0]}}, '0, 2'h0);
        end
        // Back-to-back random traffic over a few words
        repeat (60) access(1'($urandom), 14'($urandom & 32'h3007), 16'($urandom),
                           2'($urandom));
        // Reset in mid-write, then traffic resumes
        access(1'b1, 14'h0100, 16'hffff, 2'h3);
        // Request while busy is refused; reset lands with the strobe low
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
        chk_bit(write_n, 1'b0);
        resetn = 1'b0;
        @(negedge ref_clk);
        chk_bit(low_byte_strobe_n, 1'b0);
        @(negedge ref_clk);
        chk_bit(select_high, 1'b0);
        chk_bit(write_n, 1'b1);
        resetn = 1'b1;
        access(1'b0, 14'h3fff, '0, 2'h0);
        access(1'b0, 14'h0100, '0, 2'h0);
        chk_word(16'(viol), '0);
        end_of_test();
    end
endmodule // async_byte_write_sram_port_tb_top
`default_nettype wire
